/* File: hdl/fsb_pkg.sv */
package fsb_pkg;
  // ----------------------------------------------------------------
  // read configuration register layout
  // ----------------------------------------------------------------
  localparam int unsigned CFG_W = 16;
  localparam int unsigned MODE_BIT = 15;       // read_mode_select: 1 async, 0 sync burst
  localparam int unsigned FREQ_LSB = 11;       // frequency configuration code, 3 bits
  localparam int unsigned VALID_TIMING_BIT = 8; // valid_timing_select
  localparam int unsigned EDGE_BIT = 6;        // clock_edge_select: 1 rising, 0 falling
  localparam int unsigned NO_WRAP_BIT = 3;     // no_wrap_select
  localparam int unsigned LEN_LSB = 0;         // burst_length_field, 3 bits
  localparam logic [15:0] CFG_RESET = 16'h9841; // async mode, code 3, rising edge, 4-word

  // ----------------------------------------------------------------
  // burst length codes and command codes
  // ----------------------------------------------------------------
  localparam logic [2:0] LEN_4 = 3'h1;
  localparam logic [2:0] LEN_8 = 3'h2;
  localparam logic [2:0] LEN_CONT = 3'h7;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ROW_BITS = 4;        // output delay when a burst enters a new 16-word row

  typedef enum logic [1:0] {L_IDLE, L_LAT, L_BURST, L_DONE} fsb_link_e;
endpackage

/* File: hdl/fsb_mem.sv */
`timescale 1ns/1ns
// dual clock array: port a loads and reads on the system clock, port b reads on the link clock
module fsb_mem #(
  parameter int unsigned AW = 22,
  parameter int unsigned DW = 16
) (
  // port a, system clock
  input wire logic clk_a,
  input wire logic wr_a,
  input wire logic [AW-1:0] addr_a,
  input wire logic [DW-1:0] wdata_a,
  output logic [DW-1:0] rdata_a,
  // port b, link clock
  input wire logic clk_b,
  input wire logic [AW-1:0] addr_b,
  output logic [DW-1:0] rdata_b
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // ----------------------------------------------------------------
  // port a write and registered read
  // ----------------------------------------------------------------
  always_ff @(posedge clk_a) begin
    if (wr_a) begin
      mem[addr_a] <= wdata_a;
    end
    rdata_a <= mem[addr_a];
  end

  // ----------------------------------------------------------------
  // port b registered read
  // ----------------------------------------------------------------
  always_ff @(posedge clk_b) begin
    rdata_b <= mem[addr_b];
  end
endmodule

/* File: hdl/fsb_read_port.sv */
`timescale 1ns/1ns
// Summary of operation
// - bursts only from array, never special data
// - bursts stop at a partition boundary
// - first word after latency, then one per clock
// - reset selects asynchronous read mode
// - four-word, eight-word and continuous bursts
// - length code 001 gives four words
// - valid indicator used in continuous or no-wrap
// - indicator high valid, low during delay
// - indicator driven only with select and enable
// - indicator low in delay or one before
// - delays only in continuous or no-wrap bursts
// - code n gives n latency clocks, code 0 gives one
// - special data served by single reads only
// - async reads ignore clock, latch on strobe
// - single sync data on selected clock edge
// - sync address latched on strobe or edge
// - command 98h selects query read mode
// - mode bit one async, zero burst
// - latch open while strobe low, closes on edge
// - async mode holds indicator high
module fsb_read_port #(
  parameter int unsigned AW = 21,
  parameter int unsigned PART_BITS = 2
) (
  // system clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // read clock from the host
  input wire logic flash_clk,
  // configuration and command, system clock
  input wire logic cfg_wr,
  input wire logic [15:0] cfg_wdata,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [PART_BITS-1:0] cmd_partition,
  // array load, system clock
  input wire logic load_en,
  input wire logic [AW:0] load_addr,
  input wire logic [15:0] load_data,
  // host pins
  input wire logic address_strobe_n,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic [AW-1:0] addr,
  // data pins, asynchronous path
  output logic [15:0] async_dq,
  output logic async_dq_oe,
  // data and valid indicator pins, burst path
  output logic [15:0] burst_dq,
  output logic burst_dq_oe,
  output logic wait_out,
  output logic wait_oe,
  // status
  output logic [15:0] read_config_reg,
  output logic [(1<<PART_BITS)-1:0] partition_query
);
  localparam int unsigned NPART = 1 << PART_BITS;
  localparam int unsigned PLOW = AW - PART_BITS;
  if (AW < PART_BITS + fsb_pkg::ROW_BITS + 3) begin : g_chk
    $error("fsb_read_port: address too narrow for partitions and rows");
  end
  // next burst address: linear, or wrapping inside the 4 or 8 word group
  function automatic logic [AW-1:0] fsb_next(input logic [AW-1:0] a, input logic wrap, input logic eight);
    if (wrap && eight) begin
      return {a[AW-1:3], 3'(a[2:0] + 3'h1)};
    end else if (wrap) begin
      return {a[AW-1:2], 2'(a[1:0] + 2'h1)};
    end
    return AW'(a + 1'b1);
  endfunction

  // ----------------------------------------------------------------
  // system domain: configuration and partition read modes
  // ----------------------------------------------------------------
  logic [15:0] cfg_q;
  logic [NPART-1:0] spec_q;
  logic [NPART-1:0] query_q;

  // reset returns to asynchronous reads; software may select burst later
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfg_q <= fsb_pkg::CFG_RESET;
    end else if (cfg_wr) begin
      cfg_q <= cfg_wdata;
    end
  end

  // each partition tracks whether it reads array or special data
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      spec_q <= '0;
      query_q <= '0;
    end else if (cmd_valid) begin
      spec_q[cmd_partition] <= (cmd_code != fsb_pkg::CMD_READ_ARRAY);
      query_q[cmd_partition] <= (cmd_code == fsb_pkg::CMD_QUERY);
    end
  end

  assign read_config_reg = cfg_q;
  assign partition_query = query_q;

  // ----------------------------------------------------------------
  // system domain: single asynchronous reads
  // ----------------------------------------------------------------
  logic [2:0] as_ctl1_q;
  logic [2:0] as_ctl2_q;
  logic [AW-1:0] as_a1_q;
  logic [AW-1:0] as_a2_q;
  logic [AW-1:0] as_addr_q;
  logic as_oe_q;
  wire as_adv_n = as_ctl2_q[2];
  wire as_sel = !as_ctl2_q[1] && !as_ctl2_q[0];
  wire as_mode = cfg_q[fsb_pkg::MODE_BIT];
  wire as_spec = spec_q[as_addr_q[AW-1:PLOW]];

  // pins come from the host, two stages before use
  always_ff @(posedge mclk) begin
    as_ctl1_q <= {address_strobe_n, chip_enable_n, output_enable_n};
    as_ctl2_q <= as_ctl1_q;
    as_a1_q <= addr;
    as_a2_q <= as_a1_q;
  end

  // latch follows the bus while the strobe is low and holds from its rise
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      as_addr_q <= '0;
      as_oe_q <= 1'b0;
    end else begin
      if (!as_adv_n) begin
        as_addr_q <= as_a2_q;
      end
      as_oe_q <= as_mode && as_sel;
    end
  end

  assign async_dq_oe = as_oe_q;
  // ----------------------------------------------------------------
  // link domain: crossings in
  // ----------------------------------------------------------------
  logic lk_rst1_q;
  logic lk_rst2_q;
  logic [15:0] lk_cfg1_q;
  logic [15:0] lk_cfg2_q;
  logic [NPART-1:0] lk_spec1_q;
  logic [NPART-1:0] lk_spec2_q;
  // reset and configuration levels pass two stages into the link domain
  always_ff @(posedge flash_clk) begin
    lk_rst1_q <= resetn;
    lk_rst2_q <= lk_rst1_q;
    lk_cfg1_q <= cfg_q;
    lk_cfg2_q <= lk_cfg1_q;
    lk_spec1_q <= spec_q;
    lk_spec2_q <= lk_spec1_q;
  end

  // ----------------------------------------------------------------
  // link domain: burst sequencer
  // ----------------------------------------------------------------
  fsb_pkg::fsb_link_e st_q, st_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [2:0] lat_q, lat_d;
  logic [3:0] words_q, words_d;
  logic cont_q, cont_d;
  logic wrap_q, wrap_d;
  logic eight_q, eight_d;
  logic spec_l_q, spec_l_d;
  logic dly_en_q, dly_en_d;
  logic crossed_q, crossed_d;
  logic valid_q, valid_d;
  logic wait_q, wait_d;
  logic adv_prev_q;
  logic ce_prev_q;
  logic dq_oe_q;
  logic wait_oe_q;
  logic [15:0] dq_fall_q;
  logic [15:0] rdata_b;
  wire sync_mode = !lk_cfg2_q[fsb_pkg::MODE_BIT];
  wire early = lk_cfg2_q[fsb_pkg::VALID_TIMING_BIT];
  wire rise_sel = lk_cfg2_q[fsb_pkg::EDGE_BIT];
  wire [2:0] len_code = lk_cfg2_q[fsb_pkg::LEN_LSB +: 3];
  wire [2:0] lat_code = lk_cfg2_q[fsb_pkg::FREQ_LSB +: 3];
  wire ce_lo = !chip_enable_n;
  wire sel = ce_lo && !output_enable_n;
  wire adv_rise = address_strobe_n && !adv_prev_q;
  wire start_evt = sync_mode && ce_lo && ((!address_strobe_n && (adv_prev_q || ce_prev_q)) || adv_rise);
  wire new_spec = lk_spec2_q[addr[AW-1:PLOW]];
  wire new_cont = (len_code == fsb_pkg::LEN_CONT) && !new_spec;
  wire new_wrap = !lk_cfg2_q[fsb_pkg::NO_WRAP_BIT];
  wire row_end = &addr_q[fsb_pkg::ROW_BITS-1:0];
  wire part_end = &addr_q[PLOW-1:0];
  wire stall = dly_en_q && crossed_q;
  wire last_word = spec_l_q || part_end || (!cont_q && (words_q == 4'h1));
  wire [AW-1:0] addr_nx = fsb_next(addr_q, wrap_q && !cont_q, eight_q);

  // next-state decode for latency, data and delay cycles
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    lat_d = lat_q;
    words_d = words_q;
    cont_d = cont_q;
    wrap_d = wrap_q;
    eight_d = eight_q;
    spec_l_d = spec_l_q;
    dly_en_d = dly_en_q;
    crossed_d = crossed_q;
    valid_d = 1'b0;
    wait_d = 1'b1;
    if (!ce_lo || !sync_mode) begin
      st_d = fsb_pkg::L_IDLE;
    end else if (start_evt) begin
      st_d = fsb_pkg::L_LAT;
      addr_d = addr;
      lat_d = (lat_code == 3'h0) ? 3'h1 : lat_code;
      spec_l_d = new_spec;
      cont_d = new_cont;
      wrap_d = new_wrap;
      eight_d = (len_code == fsb_pkg::LEN_8);
      words_d = (len_code == fsb_pkg::LEN_8) ? 4'h8 : 4'h4;
      dly_en_d = !new_spec && (new_cont || !new_wrap);
      crossed_d = 1'b0;
      wait_d = !(!new_spec && (new_cont || !new_wrap));
    end else begin
      unique case (st_q)
        fsb_pkg::L_IDLE, fsb_pkg::L_DONE: ;
        fsb_pkg::L_LAT: begin
          wait_d = !dly_en_q;
          if (lat_q == 3'h1) begin
            st_d = last_word ? fsb_pkg::L_DONE : fsb_pkg::L_BURST;
            valid_d = 1'b1;
            wait_d = !(dly_en_q && early && row_end && !last_word);
            addr_d = last_word ? addr_q : addr_nx; // hold the last word, never step past the end
            words_d = 4'(words_q - 4'h1);
            crossed_d = row_end;
          end else begin
            lat_d = 3'(lat_q - 3'h1);
          end
        end
        fsb_pkg::L_BURST: begin
          if (stall) begin
            crossed_d = 1'b0;
            wait_d = early;
          end else begin
            valid_d = 1'b1;
            addr_d = last_word ? addr_q : addr_nx;
            words_d = 4'(words_q - 4'h1);
            crossed_d = row_end;
            wait_d = !(dly_en_q && early && row_end && !last_word);
            if (last_word) begin
              st_d = fsb_pkg::L_DONE;
            end
          end
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge flash_clk) begin
    if (!lk_rst2_q) begin
      st_q <= fsb_pkg::L_IDLE;
      addr_q <= '0;
      lat_q <= 3'h0;
      words_q <= 4'h0;
      cont_q <= 1'b0;
      wrap_q <= 1'b0;
      eight_q <= 1'b0;
      spec_l_q <= 1'b0;
      dly_en_q <= 1'b0;
      crossed_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      lat_q <= lat_d;
      words_q <= words_d;
      cont_q <= cont_d;
      wrap_q <= wrap_d;
      eight_q <= eight_d;
      spec_l_q <= spec_l_d;
      dly_en_q <= dly_en_d;
      crossed_q <= crossed_d;
      valid_q <= valid_d;
    end
  end

  // pin-facing registers: strobe history, enables and the valid indicator
  always_ff @(posedge flash_clk) begin
    if (!lk_rst2_q) begin
      adv_prev_q <= 1'b1;
      ce_prev_q <= 1'b1;
      dq_oe_q <= 1'b0;
      wait_oe_q <= 1'b0;
      wait_q <= 1'b1;
    end else begin
      adv_prev_q <= address_strobe_n;
      ce_prev_q <= chip_enable_n;
      dq_oe_q <= sel && sync_mode;
      wait_oe_q <= sel;
      wait_q <= sync_mode ? wait_d : 1'b1;
    end
  end

  // falling-edge copy for the falling data option
  always_ff @(negedge flash_clk) begin
    dq_fall_q <= rdata_b;
  end

  assign burst_dq = rise_sel ? rdata_b : dq_fall_q;
  assign burst_dq_oe = dq_oe_q;
  assign wait_out = wait_q;
  assign wait_oe = wait_oe_q;

  // ----------------------------------------------------------------
  // array
  // ----------------------------------------------------------------
  fsb_mem #(.AW(AW + 1), .DW(fsb_pkg::WORD_W)) u_mem (
    .clk_a(mclk),
    .wr_a(load_en),
    .addr_a(load_en ? load_addr : {as_spec, as_addr_q}),
    .wdata_a(load_data),
    .rdata_a(async_dq),
    .clk_b(flash_clk),
    .addr_b({spec_l_q, addr_q}),
    .rdata_b(rdata_b)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [3:0] vcnt_q;
  always_ff @(posedge flash_clk) begin
    if (!lk_rst2_q || start_evt) begin
      vcnt_q <= 4'h0;
    end else if (valid_q && vcnt_q != 4'hf) begin
      vcnt_q <= 4'(vcnt_q + 4'h1);
    end
  end

  sequence s_start_code2;
    start_evt && lat_code == 3'h2;
  endsequence

  a_async_wait_high: assert property (@(posedge flash_clk) disable iff (!lk_rst2_q)
    !sync_mode && !$past(sync_mode) |-> wait_q) else $error("indicator low in async mode");
  a_wait_gated: assert property (@(posedge flash_clk) disable iff (!lk_rst2_q)
    !sel |=> !wait_oe_q) else $error("indicator driven without select");
  a_latency_two: assert property (@(posedge flash_clk) disable iff (!lk_rst2_q)
    s_start_code2 ##1 (ce_lo && sync_mode)[*2] |-> !valid_q ##1 valid_q) else $error("latency wrong");
  a_special_single: assert property (@(posedge flash_clk) disable iff (!lk_rst2_q)
    valid_q && spec_l_q |=> !valid_q) else $error("burst from special data");
  a_four_words: assert property (@(posedge flash_clk) disable iff (!lk_rst2_q)
    !cont_q && !eight_q |-> vcnt_q <= 4'h4) else $error("four-word burst too long");
  a_no_delay_wrap: assert property (@(posedge flash_clk) disable iff (!lk_rst2_q)
    !dly_en_q && $fell(valid_q) |-> st_q != fsb_pkg::L_BURST) else $error("delay in wrapped burst");
  a_delay_resume: assert property (@(posedge flash_clk) disable iff (!lk_rst2_q)
    dly_en_q && $fell(valid_q) && st_q == fsb_pkg::L_BURST |=> valid_q || st_q != fsb_pkg::L_BURST)
    else $error("delay longer than one cycle");
  a_early_wait: assert property (@(posedge flash_clk) disable iff (!lk_rst2_q)
    st_q == fsb_pkg::L_BURST && early && valid_q && !wait_q |=> !valid_q || st_q != fsb_pkg::L_BURST)
    else $error("early indicator not followed by delay");
endmodule

/* File: dv/fsb_host_model.sv */
`timescale 1ns/1ns
// host side: drives strobe, selects, address and the read clock, and records what comes back
module fsb_host_model #(
  parameter int unsigned AW = 9
) (
  // system clock, used only for asynchronous cycles
  input wire logic mclk,
  // host pins
  output logic flash_clk,
  output logic address_strobe_n,
  output logic chip_enable_n,
  output logic output_enable_n,
  output logic [AW-1:0] addr,
  // answers from the flash
  input wire logic [15:0] burst_dq,
  input wire logic burst_dq_oe,
  input wire logic wait_out,
  input wire logic wait_oe,
  input wire logic [15:0] async_dq,
  input wire logic async_dq_oe
);
  logic [15:0] got_dq [0:31];
  logic [15:0] got_mid [0:31];
  logic got_wait [0:31];
  logic got_woe [0:31];
  logic got_doe [0:31];
  logic wait_pin;

  // ------------------------------------------------------------
  // pin level: pull-up holds the indicator high when not driven
  // ------------------------------------------------------------
  assign wait_pin = wait_oe ? wait_out : 1'b1;

  initial begin
    flash_clk = 1'b0;
    address_strobe_n = 1'b1;
    chip_enable_n = 1'b1;
    output_enable_n = 1'b1;
    addr = '0;
  end

  // free clocks with the part deselected; the 7 ns step keeps edges off the system grid
  task automatic idle(input int n);
    #7;
    repeat (n) begin
      flash_clk = 1'b1;
      #40;
      flash_clk = 1'b0;
      #40;
    end
  endtask

  // one framed transfer of n read clocks, samples taken just before each next rise
  task automatic burst(input logic [AW-1:0] a, input int n, input logic use_oe);
    idle(5);
    chip_enable_n <= 1'b0;
    output_enable_n <= !use_oe;
    address_strobe_n <= 1'b0; // strobe held low through the frame, latched on edge 0
    addr <= a;
    #1;
    for (int k = 0; k < n; k++) begin
      flash_clk = 1'b1;
      #39;
      got_mid[k] = burst_dq; // late in the high phase: tells rising from falling data
      #1;
      flash_clk = 1'b0;
      addr <= ~a;
      #39;
      got_dq[k] = burst_dq;
      got_wait[k] = wait_pin;
      got_woe[k] = wait_oe;
      got_doe[k] = burst_dq_oe;
      #1;
    end
    chip_enable_n <= 1'b1;
    output_enable_n <= 1'b1;
    address_strobe_n <= 1'b1;
    addr <= ~addr;
    idle(2);
  endtask

  // single asynchronous read with the read clock standing still
  task automatic async_read(input logic [AW-1:0] a, output logic [15:0] d, output logic d_oe, output logic w);
    @(posedge mclk);
    chip_enable_n <= 1'b0;
    output_enable_n <= 1'b0;
    address_strobe_n <= 1'b0;
    addr <= a;
    repeat (2) @(posedge mclk);
    address_strobe_n <= 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    d = async_dq;
    d_oe = async_dq_oe;
    w = wait_pin;
    @(posedge mclk);
    chip_enable_n <= 1'b1;
    output_enable_n <= 1'b1;
    addr <= ~a;
    repeat (6) @(posedge mclk);
  endtask
endmodule

/* File: dv/test_flash_sync_burst_read_port.sv */
`timescale 1ns/1ns
module test_flash_sync_burst_read_port;
  localparam int unsigned AW = 9;
  logic mclk, resetn, flash_clk, cfg_wr, cmd_valid, load_en;
  logic [15:0] cfg_wdata, load_data, async_dq, burst_dq, read_config_reg;
  logic [7:0] cmd_code;
  logic [1:0] cmd_partition;
  logic [AW:0] load_addr;
  logic address_strobe_n, chip_enable_n, output_enable_n, async_dq_oe, burst_dq_oe, wait_out, wait_oe;
  logic [AW-1:0] addr;
  logic [3:0] partition_query;
  int miscompares = 0;
  int comparisons = 0;

  // ------------------------------------------------------------
  // design, host model, clock
  // ------------------------------------------------------------
  fsb_read_port #(.AW(AW), .PART_BITS(2)) fsb_read_port_inst (
    .mclk(mclk), .resetn(resetn), .flash_clk(flash_clk), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_partition(cmd_partition), .load_en(load_en),
    .load_addr(load_addr), .load_data(load_data), .address_strobe_n(address_strobe_n),
    .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n), .addr(addr), .async_dq(async_dq),
    .async_dq_oe(async_dq_oe), .burst_dq(burst_dq), .burst_dq_oe(burst_dq_oe), .wait_out(wait_out),
    .wait_oe(wait_oe), .read_config_reg(read_config_reg), .partition_query(partition_query));

  fsb_host_model #(.AW(AW)) fsb_host_model_inst (
    .mclk(mclk), .flash_clk(flash_clk), .address_strobe_n(address_strobe_n), .chip_enable_n(chip_enable_n),
    .output_enable_n(output_enable_n), .addr(addr), .burst_dq(burst_dq), .burst_dq_oe(burst_dq_oe),
    .wait_out(wait_out), .wait_oe(wait_oe), .async_dq(async_dq), .async_dq_oe(async_dq_oe));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] word(input logic special, input logic [AW-1:0] a);
    return {special ? 4'ha : 4'h5, 3'h0, a}; // distinct pattern per space
  endfunction

  function automatic logic [15:0] cfg(input logic [2:0] code, input logic early, input logic rise,
                                      input logic nowrap, input logic [2:0] len);
    return {1'b0, 1'b0, code, 2'h0, early, 1'b0, rise, 2'h0, nowrap, len};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic set_cfg(input logic [15:0] v);
    @(posedge mclk);
    cfg_wr <= 1'b1;
    cfg_wdata <= v;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    #1;
    check(read_config_reg, v);
  endtask

  task automatic send_cmd(input logic [7:0] c, input logic [1:0] p);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_partition <= p;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    #1;
  endtask

  // one burst judged word by word; len 0 means continuous
  task automatic run_burst(input logic [AW-1:0] a, input logic [2:0] code, input int len, input logic nowrap,
                           input logic early, input int nw);
    logic [15:0] ed [0:31];
    logic ew [0:31];
    logic [AW-1:0] cur;
    logic [AW-1:0] m;
    int c;
    cur = a;
    c = int'(code);
    m = AW'(len - 1);
    for (int w = 0; w < nw; w++) begin
      if (len == 0 || nowrap) begin
        if (w > 0 && cur[3:0] == 4'h0) begin // a new row costs one invalid cycle
          ed[c] = word(1'b0, cur);
          ew[c] = early;
          ew[c-1] = !early;
          c++;
        end
        ed[c] = word(1'b0, cur);
        cur++;
      end else begin
        ed[c] = word(1'b0, (a & ~m) | ((a + AW'(w)) & m));
      end
      ew[c] = 1'b1;
      c++;
    end
    fsb_host_model_inst.burst(a, c + 1, 1'b1);
    for (int k = int'(code); k < c; k++) begin
      check(fsb_host_model_inst.got_dq[k], ed[k]);
      check(16'(fsb_host_model_inst.got_wait[k]), 16'(ew[k]));
      check(16'({fsb_host_model_inst.got_woe[k], fsb_host_model_inst.got_doe[k]}), 16'h3);
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_async();
    logic [15:0] d;
    logic d_oe, w;
    fsb_host_model_inst.async_read(9'd37, d, d_oe, w);
    check(d, word(1'b0, 9'd37));
    check(16'({d_oe, w}), 16'h3);
    send_cmd(8'h90, 2'h1);
    fsb_host_model_inst.async_read(9'd137, d, d_oe, w);
    check(d, word(1'b1, 9'd137));
    send_cmd(8'h98, 2'h2);
    check(16'(partition_query), 16'h4);
    fsb_host_model_inst.async_read(9'd259, d, d_oe, w);
    check(d, word(1'b1, 9'd259));
    send_cmd(8'hff, 2'h2);
    check(16'(partition_query), 16'h0);
    fsb_host_model_inst.burst(9'd8, 6, 1'b1);
    check(16'(fsb_host_model_inst.got_doe[4]), 16'h0);
    check(16'(fsb_host_model_inst.got_wait[4]), 16'h1);
  endtask

  task automatic t_fixed();
    for (int n = 2; n <= 4; n++) begin
      set_cfg(cfg(3'(n), 1'b0, 1'b1, 1'b0, fsb_pkg::LEN_4));
      run_burst(9'd6, 3'(n), 4, 1'b0, 1'b0, 4);
    end
    set_cfg(cfg(3'h3, 1'b0, 1'b1, 1'b0, fsb_pkg::LEN_8));
    run_burst(9'd29, 3'h3, 8, 1'b0, 1'b0, 8);
    check(fsb_host_model_inst.got_mid[4], word(1'b0, 9'd30));
    set_cfg(cfg(3'h3, 1'b0, 1'b0, 1'b0, fsb_pkg::LEN_4));
    run_burst(9'd41, 3'h3, 4, 1'b0, 1'b0, 4);
    check(fsb_host_model_inst.got_mid[4], word(1'b0, 9'd41));
    set_cfg(cfg(3'h2, 1'b0, 1'b1, 1'b1, fsb_pkg::LEN_8));
    run_burst(9'd76, 3'h2, 8, 1'b1, 1'b0, 8);
  endtask

  task automatic t_cont();
    for (int e = 0; e <= 1; e++) begin
      set_cfg(cfg(3'h2, 1'(e), 1'b1, 1'b0, fsb_pkg::LEN_CONT));
      run_burst(9'd44, 3'h2, 0, 1'b0, 1'(e), 6);
    end
    fsb_host_model_inst.burst(9'd126, 8, 1'b1);
    check(fsb_host_model_inst.got_dq[3], word(1'b0, 9'd127));
    check(16'(fsb_host_model_inst.got_dq[5] === word(1'b0, 9'd128)), 16'h0);
    fsb_host_model_inst.burst(9'd44, 8, 1'b0);
    check(16'({fsb_host_model_inst.got_woe[4], fsb_host_model_inst.got_wait[4]}), 16'h1);
    send_cmd(8'h90, 2'h1);
    fsb_host_model_inst.burst(9'd133, 8, 1'b1);
    check(fsb_host_model_inst.got_dq[2], word(1'b1, 9'd133));
    check(16'(fsb_host_model_inst.got_dq[3] === word(1'b1, 9'd134)), 16'h0);
    fsb_host_model_inst.burst(9'd134, 8, 1'b1);
    check(fsb_host_model_inst.got_dq[2], word(1'b1, 9'd134));
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    {cfg_wr, cmd_valid, load_en, cfg_wdata, cmd_code, cmd_partition, load_addr, load_data} = '0;
    fsb_host_model_inst.idle(4); // link side needs clocks during reset
    @(posedge mclk);
    resetn <= 1'b1;
    #1;
    check(read_config_reg, fsb_pkg::CFG_RESET);
    check(16'({partition_query, wait_out, burst_dq_oe, async_dq_oe}), 16'h4);
    for (int i = 0; i < 1024; i++) begin
      @(posedge mclk);
      load_en <= 1'b1;
      load_addr <= (AW+1)'(i);
      load_data <= word(1'(i >> AW), AW'(i));
    end
    @(posedge mclk);
    load_en <= 1'b0;
    t_async();
    t_fixed();
    t_cont();
    wrap_up();
  end

  initial begin
    repeat (40000) @(posedge mclk);
    miscompares++;
    wrap_up();
  end
endmodule
